// >>> verilog/upm_pkg.sv
// package: register map, field positions and carriers for the pipe mask set/clear block
package upm_pkg;
  // ==========================================================================
  // geometry
  localparam int UPM_NUM_PIPES = 5;
  localparam int UPM_ADDR_W = 32;
  localparam int UPM_DATA_W = 32;
  localparam int UPM_PIPE_W = 3;
  localparam int UPM_PIPE_TYPE_W = 2;
  // ==========================================================================
  // register bases, one word per pipe
  localparam logic [31:0] UPM_MASK_SET_BASE = 32'h400205F0;
  localparam logic [31:0] UPM_MASK_CLR_BASE = 32'h40020620;
  localparam logic [31:0] UPM_MASK_VIEW_BASE = 32'h400205C0;
  localparam logic [31:0] UPM_PIPE_TYPE_BASE = 32'h40020700;
  localparam logic [31:0] UPM_WORD_BYTES = 32'h00000004;
  // ==========================================================================
  // pipe type codes
  localparam logic [1:0] UPM_PIPE_TYPE_CTRL = 2'h0;
  localparam logic [1:0] UPM_PIPE_TYPE_ISO = 2'h1;
  localparam logic [1:0] UPM_PIPE_TYPE_BULK = 2'h2;
  localparam logic [1:0] UPM_PIPE_TYPE_INTR = 2'h3;
  // ==========================================================================
  // bit positions shared by set port, clear port and mask
  localparam int UPM_B_RX_IN = 0;
  localparam int UPM_B_TX_OUT = 1;
  localparam int UPM_B_TYPE2 = 2;
  localparam int UPM_B_PERR = 3;
  localparam int UPM_B_NAKED = 4;
  localparam int UPM_B_OVERF = 5;
  localparam int UPM_B_TYPE6 = 6;
  localparam int UPM_B_SHORT = 7;
  localparam int UPM_B_BUSY = 12;
  localparam int UPM_B_BANK = 14;
  localparam int UPM_B_DMA = 16;
  localparam int UPM_B_HALT = 17;
  localparam int UPM_B_TOGGLE = 18;
  localparam logic [31:0] UPM_IRQ_BITS = 32'h000010FF;
  localparam logic [31:0] UPM_CTRL_BITS = 32'h00030000;
  localparam logic [31:0] UPM_MASK_RESET = 32'h00000000;
  // ==========================================================================
  // register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [UPM_ADDR_W-1:0] addr;
    logic [UPM_DATA_W-1:0] wdata;
  } upm_bus_req_t;
  // per-pipe strobes toward the engine
  typedef struct packed {
    logic bank_release;
    logic toggle_reset;
  } upm_pipe_evt_t;
endpackage

// >>> verilog/upm_sync2.sv
// two-flop synchroniser for a status level from the engine
`timescale 1ns/1ps
module upm_sync2 import upm_pkg::*; #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // upm_sync2

// >>> verilog/upm_pipe_mask.sv
// one pipe's interrupt-enable mask with set/clear ports
`timescale 1ns/1ps
module upm_pipe_mask import upm_pkg::*; (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic set_wr,
  input wire logic clr_wr,
  input wire logic [UPM_DATA_W-1:0] wdata,
  input wire logic [UPM_PIPE_TYPE_W-1:0] pipe_type,
  input wire logic toggle_done,
  input wire logic bank_refill,
  input wire logic halt_event,
  output logic [UPM_DATA_W-1:0] pipe_irq_mask,
  output upm_pipe_evt_t evt
);
  localparam logic [UPM_DATA_W-1:0] SET_MASK = UPM_IRQ_BITS | UPM_CTRL_BITS;
  localparam logic [UPM_DATA_W-1:0] CLR_MASK = SET_MASK | (UPM_DATA_W'(1) << UPM_B_BANK);
  logic [UPM_DATA_W-1:0] set_bits;
  logic [UPM_DATA_W-1:0] clr_bits;
  logic [UPM_B_BANK-1:0] irq_en;
  logic bank_control;
  logic dma_gate;
  logic pipe_halt;
  logic toggle_reset_pending;
  logic bank_release;
  logic toggle_reset;
  // ==========================================================================
  // type-dependent bit meanings
  always_comb begin
    set_bits = set_wr ? (wdata & SET_MASK) : '0;
    clr_bits = clr_wr ? (wdata & CLR_MASK) : '0;
    // bits 2 and 6 mean setup/underflow and stalled/crc by type, one flop each
    unique case (pipe_type)
      UPM_PIPE_TYPE_CTRL, UPM_PIPE_TYPE_BULK: begin
      end
      UPM_PIPE_TYPE_INTR: begin
      end
      UPM_PIPE_TYPE_ISO: begin
      end
    endcase
  end
  // ==========================================================================
  // mask flops
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_en <= UPM_MASK_RESET[UPM_B_BANK-1:0];
      dma_gate <= UPM_MASK_RESET[UPM_B_DMA];
    end else begin
      irq_en <= (irq_en & ~clr_bits[UPM_B_BANK-1:0])
        | set_bits[UPM_B_BANK-1:0];
      dma_gate <= set_bits[UPM_B_DMA]
        | (dma_gate & ~clr_bits[UPM_B_DMA]);
    end
  end
  // bank control: hardware refill wins over software clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bank_control <= UPM_MASK_RESET[UPM_B_BANK];
      bank_release <= 1'b0;
    end else begin
      bank_control <= bank_refill
        | (bank_control & ~clr_bits[UPM_B_BANK]);
      bank_release <= clr_bits[UPM_B_BANK] & bank_control;
    end
  end
  // halt: set by software or engine event, cleared by software
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pipe_halt <= UPM_MASK_RESET[UPM_B_HALT];
    end else begin
      pipe_halt <= set_bits[UPM_B_HALT] | halt_event
        | (pipe_halt & ~clr_bits[UPM_B_HALT]);
    end
  end
  // toggle reset: pending until the engine reports done; new request wins
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      toggle_reset_pending <= UPM_MASK_RESET[UPM_B_TOGGLE];
      toggle_reset <= 1'b0;
    end else begin
      toggle_reset_pending <= (set_wr & wdata[UPM_B_TOGGLE])
        | (toggle_reset_pending & ~toggle_done);
      toggle_reset <= set_wr & wdata[UPM_B_TOGGLE];
    end
  end
  // ==========================================================================
  // mask word as seen by software, unused bits zero
  always_comb begin
    pipe_irq_mask = '0;
    pipe_irq_mask[UPM_B_BANK-1:0] = irq_en;
    pipe_irq_mask[UPM_B_BANK] = bank_control;
    pipe_irq_mask[UPM_B_DMA] = dma_gate;
    pipe_irq_mask[UPM_B_HALT] = pipe_halt;
    pipe_irq_mask[UPM_B_TOGGLE] = toggle_reset_pending;
  end
  assign evt = '{bank_release: bank_release, toggle_reset: toggle_reset};
endmodule // upm_pipe_mask

// >>> verilog/upm_top.sv
// top: register slave for the per-pipe mask set/clear ports of a usb host controller
// What this block does
// - toggle reset request flags pending, resets toggle
// - set and clear ports read as zero
// - clear port ones clear mask bits
// - set port ones set mask bits
// - control/bulk layout for types 0 and 2
// - interrupt type: bit2 underflow, bit6 stalled
// - isochronous type: bit2 underflow, bit6 crc error
// - control/bulk: bit2 setup, bit6 stalled
// - bits 0,1 clear in and out enables
// - bits 3,4,5 clear error, naked, overflow
// - bits 7,12 clear short packet, busy banks
// - clear bit14 clears bank control, no setter
// - clear bits 16,17 clear dma gate, halt
// - set bits 16,17 set dma gate, halt
// - set port has toggle reset setter
// - five pipe instances, indices zero to four
// - bank control clear sends or frees bank
// - clearing halt re-enables request generation
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module upm_top import upm_pkg::*; #(
  parameter int NUM_PIPES = UPM_NUM_PIPES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [UPM_ADDR_W-1:0] bus_addr,
  input wire logic [UPM_DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [UPM_DATA_W-1:0] bus_rdata,
  input wire logic [NUM_PIPES-1:0] toggle_done,
  input wire logic [NUM_PIPES-1:0] bank_refill,
  input wire logic [NUM_PIPES-1:0] halt_event,
  output logic [NUM_PIPES-1:0] pipe_halt,
  output logic [NUM_PIPES-1:0] irq_blocks_dma,
  output logic [NUM_PIPES-1:0] bank_release,
  output logic [NUM_PIPES-1:0] toggle_reset,
  output logic [NUM_PIPES*UPM_DATA_W-1:0] pipe_irq_mask_flat,
  output logic [NUM_PIPES*UPM_PIPE_TYPE_W-1:0] pipe_type_flat
);
  upm_bus_req_t req;
  logic [NUM_PIPES-1:0] done_s;
  logic [NUM_PIPES-1:0] refill_s;
  logic [NUM_PIPES-1:0] halt_s;
  logic [NUM_PIPES-1:0] set_hit;
  logic [NUM_PIPES-1:0] clr_hit;
  logic [NUM_PIPES-1:0] view_hit;
  logic [NUM_PIPES-1:0] pipe_type_hit;
  logic [UPM_PIPE_TYPE_W-1:0] pipe_type [NUM_PIPES];
  logic [UPM_DATA_W-1:0] mask [NUM_PIPES];
  upm_pipe_evt_t evt [NUM_PIPES];
  logic [UPM_DATA_W-1:0] next_rdata;
  assign req = '{wr: bus_wr, rd: bus_rd, addr: bus_addr, wdata: bus_wdata};
  // ==========================================================================
  // engine levels cross in through two flops
  upm_sync2 #(.W(3*NUM_PIPES)) u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .d({toggle_done, bank_refill, halt_event}),
    .q({done_s, refill_s, halt_s})
  );
  // ==========================================================================
  // address decode per pipe
  always_comb begin
    for (int i = 0; i < NUM_PIPES; i++) begin
      set_hit[i] = req.addr == UPM_MASK_SET_BASE + UPM_WORD_BYTES * 32'(i);
      clr_hit[i] = req.addr == UPM_MASK_CLR_BASE + UPM_WORD_BYTES * 32'(i);
      view_hit[i] = req.addr == UPM_MASK_VIEW_BASE + UPM_WORD_BYTES * 32'(i);
      pipe_type_hit[i] = req.addr == UPM_PIPE_TYPE_BASE + UPM_WORD_BYTES * 32'(i);
    end
  end
  // ==========================================================================
  // pipe type configuration
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_PIPES; i++) begin
        pipe_type[i] <= UPM_PIPE_TYPE_CTRL;
      end
    end else begin
      for (int i = 0; i < NUM_PIPES; i++) begin
        if (req.wr && pipe_type_hit[i]) begin
          pipe_type[i] <= req.wdata[UPM_PIPE_TYPE_W-1:0];
        end
      end
    end
  end
  // ==========================================================================
  // pipes
  for (genvar g = 0; g < NUM_PIPES; g++) begin : g_pipe
    upm_pipe_mask u_pipe (
      .core_clk(core_clk),
      .rstn(rstn),
      .set_wr(req.wr & set_hit[g]),
      .clr_wr(req.wr & clr_hit[g]),
      .wdata(req.wdata),
      .pipe_type(pipe_type[g]),
      .toggle_done(done_s[g]),
      .bank_refill(refill_s[g]),
      .halt_event(halt_s[g]),
      .pipe_irq_mask(mask[g]),
      .evt(evt[g])
    );
  end
  // ==========================================================================
  // read mux: set and clear ports read zero
  always_comb begin
    next_rdata = '0;
    for (int i = 0; i < NUM_PIPES; i++) begin
      if (view_hit[i]) begin
        next_rdata = mask[i];
      end
      if (pipe_type_hit[i]) begin
        next_rdata = UPM_DATA_W'(pipe_type[i]);
      end
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bus_rdata <= '0;
    end else begin
      bus_rdata <= req.rd ? next_rdata : '0;
    end
  end
  // ==========================================================================
  // registered outputs toward the engine
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pipe_halt <= '0;
      irq_blocks_dma <= '0;
      bank_release <= '0;
      toggle_reset <= '0;
      pipe_irq_mask_flat <= '0;
      pipe_type_flat <= '0;
    end else begin
      for (int i = 0; i < NUM_PIPES; i++) begin
        pipe_halt[i] <= mask[i][UPM_B_HALT];
        irq_blocks_dma[i] <= mask[i][UPM_B_DMA];
        bank_release[i] <= evt[i].bank_release;
        toggle_reset[i] <= evt[i].toggle_reset;
        pipe_irq_mask_flat[i*UPM_DATA_W +: UPM_DATA_W] <= mask[i];
        pipe_type_flat[i*UPM_PIPE_TYPE_W +: UPM_PIPE_TYPE_W] <= pipe_type[i];
      end
    end
  end
endmodule // upm_top

// >>> tb/upm_props.sv
// checker: port-level properties of the pipe mask set/clear block
`timescale 1ns/1ps
module upm_props import upm_pkg::*; #(
  parameter int NUM_PIPES = UPM_NUM_PIPES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [UPM_ADDR_W-1:0] bus_addr,
  input wire logic [UPM_DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [UPM_DATA_W-1:0] bus_rdata,
  input wire logic [NUM_PIPES-1:0] halt_event,
  input wire logic [NUM_PIPES-1:0] pipe_halt,
  input wire logic [NUM_PIPES-1:0] irq_blocks_dma,
  input wire logic [NUM_PIPES-1:0] bank_release,
  input wire logic [NUM_PIPES-1:0] toggle_reset
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ==========================================================================
  // properties
  AST_RD_IDLE: assert property (!$past(bus_rd) |-> bus_rdata == '0)
    else $error("read data not zero outside a read");
  AST_SET_RD_ZERO: assert property (bus_rd && bus_addr >= UPM_MASK_SET_BASE
    && bus_addr < UPM_MASK_SET_BASE + 32'h14 |=> bus_rdata == '0)
    else $error("set port read not zero");
  AST_CLR_RD_ZERO: assert property (bus_rd && bus_addr >= UPM_MASK_CLR_BASE
    && bus_addr < UPM_MASK_CLR_BASE + 32'h14 |=> bus_rdata == '0)
    else $error("clear port read not zero");
  AST_HALT_SET: assert property (bus_wr && bus_addr == UPM_MASK_SET_BASE
    && bus_wdata[UPM_B_HALT] |-> ##2 pipe_halt[0]) else $error("halt not set");
  AST_HALT_CLR: assert property (bus_wr && bus_addr == UPM_MASK_CLR_BASE
    && bus_wdata[UPM_B_HALT] && !halt_event[0] && !$past(halt_event[0])
    && !$past(halt_event[0], 2) && !$past(halt_event[0], 3) |-> ##2 !pipe_halt[0])
    else $error("halt not cleared");
  AST_DMA_SET: assert property (bus_wr && bus_addr == UPM_MASK_SET_BASE
    && bus_wdata[UPM_B_DMA] |-> ##2 irq_blocks_dma[0]) else $error("dma gate not set");
  AST_DMA_CLR: assert property (bus_wr && bus_addr == UPM_MASK_CLR_BASE
    && bus_wdata[UPM_B_DMA] |-> ##2 !irq_blocks_dma[0]) else $error("dma gate not cleared");
  AST_TOGGLE_PULSE: assert property (bus_wr && bus_addr == UPM_MASK_SET_BASE
    && bus_wdata[UPM_B_TOGGLE] |-> ##2 toggle_reset[0]) else $error("no toggle pulse");
  AST_BANK_CAUSE: assert property (bank_release[0] |-> $past(bus_wr, 2)
    && $past(bus_addr, 2) == UPM_MASK_CLR_BASE
    && ($past(bus_wdata, 2) & 32'h00004000) != 32'h0) else $error("bank release uncaused");
endmodule // upm_props
bind upm_top upm_props #(.NUM_PIPES(NUM_PIPES)) upm_props_i (.core_clk(core_clk), .rstn(rstn),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .halt_event(halt_event), .pipe_halt(pipe_halt),
  .irq_blocks_dma(irq_blocks_dma), .bank_release(bank_release), .toggle_reset(toggle_reset));

// >>> tb/testbench.sv
// testbench: register-level tests of the pipe mask set/clear block
`timescale 1ns/1ps
module testbench import upm_pkg::*;;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] bus_addr = '0;
  logic [31:0] bus_wdata = '0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [4:0] toggle_done = '0;
  logic [4:0] bank_refill = '0;
  logic [4:0] halt_event = '0;
  logic [31:0] bus_rdata;
  logic [4:0] pipe_halt, irq_blocks_dma, bank_release, toggle_reset;
  logic [159:0] pipe_irq_mask_flat;
  logic [9:0] pipe_type_flat;
  logic [31:0] exp;
  int n_fail = 0;
  int checks_done = 0;
  int n_rel = 0;
  int n_tgl = 0;
  upm_top upm_top_i (.core_clk(core_clk), .rstn(rstn), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .toggle_done(toggle_done), .bank_refill(bank_refill), .halt_event(halt_event),
    .pipe_halt(pipe_halt), .irq_blocks_dma(irq_blocks_dma), .bank_release(bank_release),
    .toggle_reset(toggle_reset), .pipe_irq_mask_flat(pipe_irq_mask_flat),
    .pipe_type_flat(pipe_type_flat));
  // ==========================================================================
  // clock, watchdog and helpers
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    #2000000;
    n_fail++;
    wrap_up();
  end
  always @(posedge core_clk) begin
    if (bank_release[0] === 1'b1) n_rel <= n_rel + 1;
    if (toggle_reset[0] === 1'b1) n_tgl <= n_tgl + 1;
  end
  function automatic logic [31:0] adr(input logic [31:0] base, input int i);
    return base + UPM_WORD_BYTES * 32'(i);
  endfunction
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, want, got);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge core_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] want, input string what);
    @(posedge core_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    #1;
    chk(what, bus_rdata, want);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================================================
  // tests
  initial begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(adr(UPM_MASK_SET_BASE, i), 32'h0, "set read");
      rd(adr(UPM_MASK_CLR_BASE, i), 32'h0, "clear read");
      rd(adr(UPM_MASK_VIEW_BASE, i), UPM_MASK_RESET, "mask reset");
      wr(adr(UPM_MASK_SET_BASE, i), 32'h1 << i);
    end
    wr(32'h40021000, 32'hFFFFFFFF);
    rd(32'h40021000, 32'h0, "unmapped");
    for (int i = 0; i < 5; i++) begin
      rd(adr(UPM_MASK_VIEW_BASE, i), 32'h1 << i, "pipe select");
    end
    for (int t = 0; t < 4; t++) begin
      wr(UPM_PIPE_TYPE_BASE, 32'(t));
      rd(UPM_PIPE_TYPE_BASE, 32'(t), "pipe type");
      wr(UPM_MASK_SET_BASE, 32'hFFFFFFFF);
      exp = UPM_IRQ_BITS | UPM_CTRL_BITS | 32'h00040000;
      rd(UPM_MASK_VIEW_BASE, exp, "all set");
      chk("dma out", {31'h0, irq_blocks_dma[0]}, 32'h1);
      chk("halt set out", {31'h0, pipe_halt[0]}, 32'h1);
      wr(UPM_MASK_CLR_BASE, 32'h00040000);
      wr(UPM_MASK_CLR_BASE, 32'h0);
      rd(UPM_MASK_VIEW_BASE, exp, "clear zeros");
      for (int b = 0; b < 18; b++) begin
        if (exp[b]) begin
          wr(UPM_MASK_CLR_BASE, 32'h1 << b);
          exp[b] = 1'b0;
          rd(UPM_MASK_VIEW_BASE, exp, "clear bit");
        end
      end
    end
    chk("type out", {30'h0, pipe_type_flat[1:0]}, 32'h3);
    chk("mask out", pipe_irq_mask_flat[31:0], exp);
    chk("toggle pulses", 32'(n_tgl), 32'h4);
    @(posedge core_clk);
    toggle_done[0] <= 1'b1;
    repeat (5) @(posedge core_clk);
    toggle_done[0] <= 1'b0;
    rd(UPM_MASK_VIEW_BASE, 32'h0, "toggle done");
    wr(UPM_MASK_SET_BASE, 32'h00004000);
    rd(UPM_MASK_VIEW_BASE, 32'h0, "no bank setter");
    @(posedge core_clk);
    bank_refill[0] <= 1'b1;
    repeat (5) @(posedge core_clk);
    bank_refill[0] <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd(UPM_MASK_VIEW_BASE, 32'h00004000, "bank filled");
    wr(UPM_MASK_CLR_BASE, 32'h00004000);
    repeat (3) @(posedge core_clk);
    chk("bank release", 32'(n_rel), 32'h1);
    rd(UPM_MASK_VIEW_BASE, 32'h0, "bank cleared");
    @(posedge core_clk);
    halt_event[0] <= 1'b1;
    repeat (5) @(posedge core_clk);
    halt_event[0] <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd(UPM_MASK_VIEW_BASE, 32'h00020000, "engine halt");
    wr(UPM_MASK_CLR_BASE, 32'h00020000);
    repeat (3) @(posedge core_clk);
    chk("halt out", {31'h0, pipe_halt[0]}, 32'h0);
    wrap_up();
  end
endmodule // testbench
